// ---- logic/ipts_top.sv ----
// Indexed-port timeout supervisor: config interface, countdown and system reset
`timescale 1ns/1ps
module ipts_top #(
  parameter int unsigned SEC_CYCLES = ipts_pkg::SEC_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire ipts_pkg::ipts_io_req_t i_io,
  output logic [7:0] o_io_rdata,
  output logic o_sys_reset
);

  // ----------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------
  ipts_pkg::ipts_lock_t lock;
  ipts_pkg::ipts_lock_t next_lock;
  logic [7:0] index;
  logic [7:0] ldn;
  logic [7:0] act;
  logic [7:0] unit;
  logic [7:0] count;
  logic [4:0] hold;
  logic sec_tick;
  logic min_tick;

  wire idx_wr = i_io.wr && (i_io.addr == ipts_pkg::INDEX_PORT);
  wire data_wr = i_io.wr && (i_io.addr == ipts_pkg::DATA_PORT);
  wire data_rd = i_io.rd && (i_io.addr == ipts_pkg::DATA_PORT);
  wire is_key = (i_io.wdata == ipts_pkg::UNLOCK_KEY);
  wire open = (lock == ipts_pkg::LK_OPEN);
  wire sup_sel = (ldn == ipts_pkg::LDN_SUPERVISOR);
  wire cfg_wr = data_wr && open;
  wire wr_ldn = cfg_wr && (index == ipts_pkg::REG_LDN);
  wire wr_act = cfg_wr && sup_sel && (index == ipts_pkg::REG_ACT);
  wire wr_unit = cfg_wr && sup_sel && (index == ipts_pkg::REG_UNIT);
  wire wr_count = cfg_wr && sup_sel && (index == ipts_pkg::REG_COUNT);

  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  always_comb begin
    case (lock)
      ipts_pkg::LK_LOCKED: next_lock = (idx_wr && is_key) ? ipts_pkg::LK_HALF : ipts_pkg::LK_LOCKED; // RQ4
      ipts_pkg::LK_HALF: begin
        if (idx_wr) begin
          next_lock = is_key ? ipts_pkg::LK_OPEN : ipts_pkg::LK_LOCKED; // RQ4
        end else begin
          next_lock = ipts_pkg::LK_HALF;
        end
      end
      ipts_pkg::LK_OPEN: next_lock = ipts_pkg::LK_OPEN;
      default: next_lock = ipts_pkg::LK_LOCKED;
    endcase
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  wire [7:0] sup_val = (index == ipts_pkg::REG_ACT) ? act :
                       (index == ipts_pkg::REG_UNIT) ? unit :
                       (index == ipts_pkg::REG_COUNT) ? count : ipts_pkg::RESET_VALUE;
  wire [7:0] rd_val = !open ? ipts_pkg::READ_LOCKED :
                      (index == ipts_pkg::REG_LDN) ? ldn :
                      sup_sel ? sup_val : ipts_pkg::RESET_VALUE; // RQ3

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lock <= ipts_pkg::LK_LOCKED;
      index <= ipts_pkg::RESET_VALUE;
      ldn <= ipts_pkg::RESET_VALUE;
      act <= ipts_pkg::RESET_VALUE;
      unit <= ipts_pkg::UNIT_SECONDS;
      o_io_rdata <= ipts_pkg::RESET_VALUE;
    end else begin
      lock <= next_lock;
      if (idx_wr && open) begin
        index <= i_io.wdata; // RQ10
      end
      if (wr_ldn) begin
        ldn <= i_io.wdata; // RQ5
      end
      if (wr_act) begin
        act <= i_io.wdata; // RQ6
      end
      if (wr_unit) begin
        unit <= i_io.wdata; // RQ7
      end
      if (data_rd) begin
        o_io_rdata <= rd_val; // RQ3
      end
    end
  end

  // ----------------------------------------------------------------
  // Time base and countdown
  // ----------------------------------------------------------------
  wire enabled = act[ipts_pkg::ACT_ENABLE_BIT]; // RQ6
  wire restart = wr_count || wr_act; // RQ2
  wire unit_tick = unit[ipts_pkg::UNIT_MINUTE_BIT] ? min_tick : sec_tick; // RQ7
  wire step = enabled && unit_tick && (count != 8'h00);
  // Reload in the expiry cycle wins: no reset while the count is refreshed
  wire fire = step && !wr_count && (count == 8'h01); // RQ1

  ipts_ticker #(.LIMIT(SEC_CYCLES)) u_sec (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_restart(restart),
    .i_step(1'b1),
    .o_tick(sec_tick)
  );

  ipts_ticker #(.LIMIT(ipts_pkg::MINUTE_SECONDS)) u_min (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_restart(restart),
    .i_step(sec_tick),
    .o_tick(min_tick)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count <= ipts_pkg::RESET_VALUE;
      hold <= 5'h00;
      o_sys_reset <= 1'b0;
    end else begin
      if (wr_count) begin
        count <= i_io.wdata; // RQ8
      end else if (step) begin
        count <= count - 8'h01; // RQ1
      end
      hold <= fire ? ipts_pkg::RESET_HOLD_CYCLES : ((hold != 5'h00) ? hold - 5'h01 : 5'h00);
      o_sys_reset <= fire || (hold > 5'h01); // RQ1
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_expiry_resets: assert property (fire |=> o_sys_reset [*8]) // RQ1
    else $error("reset not held after expiry");
  a_decrement_step: assert property (step && !wr_count |=> count == $past(count) - 8'h01) // RQ1
    else $error("counter did not decrement on unit tick");
  a_service_reloads: assert property (wr_count && (i_io.wdata > 8'h01) |=> !fire [*8]) // RQ2
    else $error("service write did not hold off expiry");
  a_count_loads: assert property (wr_count |=> count == $past(i_io.wdata)) // RQ8
    else $error("count write not loaded");
  a_read_selected: assert property (data_rd && open && index == ipts_pkg::REG_LDN |=> o_io_rdata == $past(ldn)) // RQ3
    else $error("data read returned wrong register");
  a_unlock_second: assert property (lock == ipts_pkg::LK_HALF && idx_wr && is_key |=> open) // RQ4
    else $error("double key did not unlock");
  a_unlock_broken: assert property (lock == ipts_pkg::LK_HALF && idx_wr && !is_key |=> lock == ipts_pkg::LK_LOCKED) // RQ4
    else $error("broken key sequence left lock open");
  a_locked_ignores: assert property (!open && data_wr |=> $stable(act) && $stable(unit) && $stable(ldn)) // RQ4
    else $error("locked write changed a register");
  a_device_gate: assert property (cfg_wr && !sup_sel && index == ipts_pkg::REG_ACT |=> $stable(act)) // RQ5
    else $error("activation written without device select");
  a_act_enable: assert property (wr_act |=> enabled == $past(i_io.wdata[ipts_pkg::ACT_ENABLE_BIT])) // RQ6
    else $error("activation bit not applied");
  a_minutes_hold: assert property (enabled && unit[ipts_pkg::UNIT_MINUTE_BIT] && !min_tick && !wr_count
                                   |=> $stable(count)) // RQ7
    else $error("minute mode stepped without minute tick");
  a_index_persist: assert property (!idx_wr |=> $stable(index)) // RQ10
    else $error("index changed without index write");

  c_unlock: cover property (lock == ipts_pkg::LK_HALF ##1 open);
  c_expire: cover property (fire ##1 o_sys_reset);
  c_minute: cover property (enabled && unit[ipts_pkg::UNIT_MINUTE_BIT] && min_tick);
  c_service: cover property (wr_count && enabled && count != 8'h00);

endmodule

// ---- logic/ipts_pkg.sv ----
// Constants, types and layout of the indexed-port timeout supervisor
// Overview of operation
// RQ1: Enabled counter counts down by time units; reaching zero pulses system reset.
// RQ2: Software rewrites the count periodically, reloading it before expiry.
// RQ3: Index port selects an internal register; data port reads or writes it.
// RQ4: Two back-to-back unlock writes to the index port open configuration access.
// RQ5: Logical-device register set to the supervisor number routes later accesses.
// RQ6: Activation register bit zero enables counting when one, disables when zero.
// RQ7: Unit register zero counts seconds, eight counts minutes.
// RQ8: Count register holds units to expiry; writing it loads the counter.
// RQ9: Software picks a timeout longer than its longest servicing interval.
// RQ10: Selected index persists until the next index-port write.
package ipts_pkg;

  // ----------------------------------------------------------------
  // Host I/O locations and register indices
  // ----------------------------------------------------------------
  localparam logic [15:0] INDEX_PORT = 16'h002e;
  localparam logic [15:0] DATA_PORT = 16'h002f;
  localparam logic [7:0] UNLOCK_KEY = 8'h87;
  localparam logic [7:0] REG_LDN = 8'h07;
  localparam logic [7:0] REG_ACT = 8'h30;
  localparam logic [7:0] REG_UNIT = 8'hf0;
  localparam logic [7:0] REG_COUNT = 8'hf1;
  localparam logic [7:0] LDN_SUPERVISOR = 8'h08;

  // ----------------------------------------------------------------
  // Field positions, values and reset values
  // ----------------------------------------------------------------
  localparam int ACT_ENABLE_BIT = 0;
  localparam int UNIT_MINUTE_BIT = 3;
  localparam logic [7:0] UNIT_SECONDS = 8'h00;
  localparam logic [7:0] UNIT_MINUTES = 8'h08;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] READ_LOCKED = 8'hff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SECOND_NS = 1000000000;
  localparam int unsigned SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned MINUTE_SECONDS = 60;
  localparam logic [4:0] RESET_HOLD_CYCLES = 5'h10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ipts_io_req_t;

  typedef enum logic [2:0] {
    LK_LOCKED = 3'b001,
    LK_HALF = 3'b010,
    LK_OPEN = 3'b100
  } ipts_lock_t;

endpackage

// ---- logic/ipts_ticker.sv ----
// Restartable divider giving a one-cycle tick every LIMIT steps
`timescale 1ns/1ps
module ipts_ticker #(
  parameter int unsigned LIMIT = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_restart,
  input wire logic i_step,
  output logic o_tick
);

  logic [31:0] cnt;
  wire last = (cnt == 32'(LIMIT - 1));

  always_ff @(posedge i_clk) begin
    if (i_rst || i_restart) begin
      cnt <= 32'h0000_0000;
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_step && last;
      if (i_step) begin
        cnt <= last ? 32'h0000_0000 : cnt + 32'h0000_0001;
      end
    end
  end

endmodule

// ---- tb/ipts_host.sv ----
// Host software model issuing I/O port requests
`timescale 1ns/1ps
module ipts_host (
  input wire logic i_clk,
  input wire logic [7:0] i_io_rdata,
  output ipts_pkg::ipts_io_req_t o_io
);
  initial begin
    o_io = '0;
  end

  // One request per call; released lines are scrambled, not held
  task automatic io_access(input logic wr, input logic [15:0] addr, input logic [7:0] data);
    @(negedge i_clk);
    o_io = '{wr: wr, rd: ~wr, addr: addr, wdata: data};
    @(negedge i_clk);
    o_io = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask

  task automatic io_read(input logic [15:0] addr, output logic [7:0] data);
    io_access(1'b0, addr, 8'h00);
    @(negedge i_clk);
    data = i_io_rdata;
  endtask
endmodule

// ---- tb/test_ipts_top.sv ----
// Self-checking testbench for the indexed-port timeout supervisor
`timescale 1ns/1ps
module test_ipts_top;
  localparam int unsigned SEC = 8;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  ipts_pkg::ipts_io_req_t io;
  logic [7:0] rdata;
  logic sys_reset;
  int err_count = 0;
  int n_compared = 0;
  int lock_cnt = 0;
  int idx = 0;
  int w;
  logic [7:0] mreg [256] = '{default: 8'h00};
  logic [7:0] got;
  logic [7:0] idxs [4] = '{8'hf1, 8'hf0, 8'h5a, 8'h30};

  ipts_top #(.SEC_CYCLES(SEC)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_io(io), .o_io_rdata(rdata),
    .o_sys_reset(sys_reset));
  ipts_host host (.i_clk(i_clk), .i_io_rdata(rdata), .o_io(io));

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task automatic close_out();
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic logic sup_reg(input int i);
    return mreg[8'h07] == ipts_pkg::LDN_SUPERVISOR && (i == 8'h30 || i == 8'hf0 || i == 8'hf1);
  endfunction

  // Reference model tracks lock state, index and registers
  task automatic mwr(input logic [15:0] a, input logic [7:0] d);
    host.io_access(1'b1, a, d);
    if (a == ipts_pkg::INDEX_PORT && lock_cnt == 2) idx = d;
    else if (a == ipts_pkg::INDEX_PORT) lock_cnt = (d == ipts_pkg::UNLOCK_KEY) ? lock_cnt + 1 : 0;
    else if (lock_cnt == 2 && (idx == 8'h07 || sup_reg(idx))) mreg[idx] = d;
  endtask

  task automatic mset(input logic [7:0] i, input logic [7:0] d);
    mwr(ipts_pkg::INDEX_PORT, i);
    mwr(ipts_pkg::DATA_PORT, d);
  endtask

  task automatic mrd();
    host.io_read(ipts_pkg::DATA_PORT, got);
    if (lock_cnt != 2) check(got, 8'hff);
    else check(got, (idx == 8'h07 || sup_reg(idx)) ? mreg[idx] : 8'h00);
  endtask

  task automatic quiet(input int n);
    w = 0;
    repeat (n) begin
      @(negedge i_clk);
      if (sys_reset !== 1'b0) w++;
    end
    check(8'(w), 8'h00);
  endtask

  // Reset must come near n cycles, then last the fixed hold time
  task automatic expire(input int n);
    w = 0;
    while (sys_reset !== 1'b1 && w < n + 6) begin
      @(negedge i_clk);
      w++;
    end
    check({7'h0, w >= n - 3 && w < n + 6}, 8'h01);
    w = 0;
    while (sys_reset === 1'b1 && w < 40) begin
      @(negedge i_clk);
      w++;
    end
    check(8'(w), {3'h0, ipts_pkg::RESET_HOLD_CYCLES});
  endtask

  initial begin
    void'($urandom(32'h6ef78aa9));
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    mrd();
    mwr(ipts_pkg::DATA_PORT, 8'h55);
    mwr(ipts_pkg::INDEX_PORT, 8'h87);
    mwr(ipts_pkg::INDEX_PORT, 8'h12);
    mwr(ipts_pkg::INDEX_PORT, 8'h87);
    mrd();
    mwr(ipts_pkg::INDEX_PORT, 8'h87);
    mset(8'hf1, 8'h21);
    mrd();
    mset(8'h07, 8'h08);
    mrd();
    foreach (idxs[k]) begin
      mset(idxs[k], 8'($urandom() & 32'hfe));
      mrd();
    end
    mset(8'hf0, ipts_pkg::UNIT_SECONDS);
    mset(8'h30, 8'h01);
    mset(8'hf1, 8'h03);
    expire(3 * SEC);
    quiet(60);
    mset(8'hf1, 8'h02);
    repeat (6) begin
      quiet(8);
      mset(8'hf1, 8'h02);
    end
    expire(2 * SEC);
    mset(8'h30, 8'h00);
    mset(8'hf1, 8'h01);
    quiet(40);
    mset(8'h30, 8'h01);
    expire(SEC);
    mset(8'hf0, ipts_pkg::UNIT_MINUTES);
    mset(8'hf1, 8'h01);
    expire(60 * SEC);
    i_rst = 1'b1;
    repeat (3) @(negedge i_clk);
    i_rst = 1'b0;
    lock_cnt = 0;
    idx = 0;
    mreg = '{default: 8'h00};
    mrd();
    quiet(20);
    close_out();
  end

  initial begin
    #200000;
    err_count++;
    close_out();
  end
endmodule
